// *** src/pmhps_pkg.sv ***
package pmhps_pkg;

   // ==========================================================
   // program memory layout
   localparam int          PC_WIDTH      = 10;
   localparam int          PAGE_BITS     = 8;
   localparam logic [9:0]  VEC_RESET     = 10'h000;
   localparam logic [9:0]  VEC_IBF       = 10'h003;
   localparam logic [9:0]  VEC_TIMER     = 10'h007;

   // ==========================================================
   // register offsets (byte addresses on the bus)
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_IN_BUF    = 8'h08;
   localparam logic [7:0]  OFS_OUT_BUF   = 8'h0C;
   localparam logic [7:0]  OFS_USER_STAT = 8'h10;
   localparam logic [7:0]  OFS_PORT1     = 8'h14;
   localparam logic [7:0]  OFS_PORT2     = 8'h18;
   localparam logic [7:0]  OFS_ALU_OP    = 8'h1C;
   localparam logic [7:0]  OFS_ALU_RES   = 8'h20;
   localparam logic [7:0]  OFS_PC        = 8'h24;
   localparam logic [7:0]  OFS_EXP       = 8'h28;

   // ==========================================================
   // control bit positions
   localparam int          CTL_IBF_IE    = 0;
   localparam int          CTL_TMR_IE    = 1;
   localparam int          CTL_FLAGS_EN  = 2;
   localparam int          CTL_DMA_EN    = 3;
   localparam int          CTL_CNT_SEL   = 4;
   localparam int          CTL_RUN       = 5;
   localparam int          CTL_WIDTH     = 6;

   // status bit positions seen by the host
   localparam int          ST_OBF        = 0;
   localparam int          ST_IBF        = 1;
   localparam int          ST_CMD        = 3;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // instruction cycle length in clocks
   localparam int          CYCLE_CLKS    = 4;

   typedef enum logic [3:0] {
      ALU_ADD, ALU_ADDC, ALU_AND, ALU_OR, ALU_XOR, ALU_INC, ALU_DEC,
      ALU_CPL, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP, ALU_DA
   } pmhps_alu_op_type;

   typedef struct packed {
      logic       chip_sel;
      logic       rd_strobe;
      logic       wr_strobe;
      logic       cmd_flag;
      logic [7:0] data;
   } pmhps_host_in_type;

endpackage : pmhps_pkg

// *** src/pmhps_alu.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmhps_alu (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      start,
   input  wire pmhps_pkg::pmhps_alu_op_type op,
   input  wire logic [7:0]                acc,
   input  wire logic [7:0]                operand,
   input  wire logic                      cy_in,
   input  wire logic                      ac_in,
   output logic      [7:0]                result_q,
   output logic                           cy_q,
   output logic                           ac_q
);
   // ==========================================================
   // combinational result
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res_d;
   logic       cy_d;
   logic       ac_d;
   logic [8:0] adj;

   always_comb begin
      sum   = 9'h000;
      nib   = 5'h00;
      adj   = 9'h000;
      res_d = result_q;
      cy_d  = cy_in;
      ac_d  = ac_in;
      unique case (op)
         pmhps_pkg::ALU_ADD, pmhps_pkg::ALU_ADDC: begin
            sum   = {1'b0, acc} + {1'b0, operand}
                    + {8'h00, (op == pmhps_pkg::ALU_ADDC) & cy_in}; // RQ22
            nib   = {1'b0, acc[3:0]} + {1'b0, operand[3:0]}
                    + {4'h0, (op == pmhps_pkg::ALU_ADDC) & cy_in};
            res_d = sum[7:0];
            cy_d  = sum[8];    // RQ20
            ac_d  = nib[4];    // RQ21
         end
         pmhps_pkg::ALU_AND:  res_d = acc & operand;
         pmhps_pkg::ALU_OR:   res_d = acc | operand;
         pmhps_pkg::ALU_XOR:  res_d = acc ^ operand;
         pmhps_pkg::ALU_INC:  res_d = acc + 8'h01;
         pmhps_pkg::ALU_DEC:  res_d = acc - 8'h01;
         pmhps_pkg::ALU_CPL:  res_d = ~acc;
         pmhps_pkg::ALU_RL:   res_d = {acc[6:0], acc[7]};
         pmhps_pkg::ALU_RR:   res_d = {acc[0], acc[7:1]};
         pmhps_pkg::ALU_RLC: begin
            res_d = {acc[6:0], cy_in};
            cy_d  = acc[7];    // RQ20
         end
         pmhps_pkg::ALU_RRC: begin
            res_d = {cy_in, acc[7:1]};
            cy_d  = acc[0];    // RQ20
         end
         pmhps_pkg::ALU_SWAP: res_d = {acc[3:0], acc[7:4]};
         pmhps_pkg::ALU_DA: begin
            // low nibble first; carry only sets
            adj = {1'b0, acc};
            if (ac_in || (acc[3:0] > 4'h9)) begin
               adj = adj + 9'h006;
            end
            if (cy_in || adj[8] || (adj[7:4] > 4'h9)) begin
               adj = adj + 9'h060;
            end
            res_d = adj[7:0];
            cy_d  = cy_in | adj[8];   // RQ21
         end
         default: res_d = result_q;
      endcase
   end

   // result and flags register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= 8'h00;
         cy_q     <= 1'b0;
         ac_q     <= 1'b0;
      end else if (start) begin
         result_q <= res_d;   // RQ23
         cy_q     <= cy_d;
         ac_q     <= ac_d;
      end
   end
endmodule : pmhps_alu
`default_nettype wire

// *** src/pmhps_top.sv ***
// Functional notes
// RQ1 - host data lines driven only during a selected host read
// RQ2 - command/data select recorded with each host write
// RQ3 - selected host write strobe captures byte into input buffer
// RQ4 - selected host read returns output buffer or status byte
// RQ5 - strobes ignored unless chip select asserted
// RQ6 - port two bits 4 and 5 can show output/input buffer full
// RQ7 - port two bits 6 and 7 can be DMA request and acknowledge
// RQ8 - low port two nibble carries expander address then data
// RQ9 - expander strobe marks expander address and data valid
// RQ10 - two quasi-bidirectional 8-bit ports, no direction register
// RQ11 - test inputs readable; second test input may clock counter
// RQ12 - exactly one cycle strobe pulse per instruction cycle
// RQ13 - single step input holds execution one instruction at a time
// RQ14 - reset clears status flip-flops and zeroes program counter
// RQ15 - first fetch after reset is from location zero
// RQ16 - enabled input-buffer-full interrupt vectors to location three
// RQ17 - enabled timer overflow interrupt vectors to location seven
// RQ18 - 10-bit program counter over 1024 bytes, sequential advance
// RQ19 - program memory organised as 256-location pages
// RQ20 - carry flag set when add or rotate exceeds 8 bits
// RQ21 - auxiliary carry set and used by BCD adjust
// RQ22 - ALU supports add, logic, inc, dec, cpl, rotates, swap, adjust
// RQ23 - ALU combines accumulator with bus operand, result returned
// RQ24 - host load of input buffer raises enabled internal interrupt
// RQ25 - host may read status any time regardless of buffer state
// RQ26 - input full set by host write, cleared by firmware read
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pmhps_top (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // host bus
   input  wire pmhps_pkg::pmhps_host_in_type host_in,
   output logic [7:0]                      host_data_out,
   output logic                            host_data_oe,
   // ports
   input  wire logic [7:0]                 port_one_lines_in,
   output logic [7:0]                      port_one_lines_out,
   input  wire logic [7:0]                 port_two_lines_in,
   output logic [7:0]                      port_two_lines_out,
   output logic                            expander_strobe,
   input  wire logic                       test_zero_in,
   input  wire logic                       event_count_input,
   input  wire logic                       single_step_in,
   input  wire logic                       external_access_in,
   output logic                            cycle_strobe_out,
   output logic [9:0]                      fetch_addr,
   output logic [7:0]                      program_status_word,
   // axi4-lite
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);
   localparam int CW = pmhps_pkg::CTL_WIDTH;

   // ==========================================================
   // state
   logic [7:0]    in_buf_q, in_buf_d;
   logic [7:0]    out_buf_q, out_buf_d;
   logic          ibf_q, ibf_d, obf_q, obf_d, cmd_q, cmd_d;
   logic [3:0]    ustat_q, ustat_d;
   logic [CW-1:0] ctrl_q, ctrl_d;
   logic [7:0]    p1_q, p1_d, p2_q, p2_d;
   logic [7:0]    timer_q, timer_d;
   logic          t1_prev_q, t1_prev_d, tmr_pend_q, tmr_pend_d;
   logic          ibf_pend_q, ibf_pend_d;
   logic [9:0]    pc_q, pc_d;
   logic [1:0]    phase_q, phase_d;
   logic          strobe_q, strobe_d, step_arm_q, step_arm_d;
   logic [7:0]    exp_q, exp_d;
   logic [2:0]    exp_cnt_q, exp_cnt_d;
   logic          exp_stb_q, exp_stb_d;
   logic [7:0]    hd_q, hd_d;
   logic          hoe_q, hoe_d;
   logic [7:0]    alu_a_q, alu_a_d, alu_b_q, alu_b_d;
   logic [3:0]    alu_op_q, alu_op_d;
   logic          alu_go_q, alu_go_d, alu_acc_q, alu_acc_d;
   logic          aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0]    awa_q, awa_d;
   logic [31:0]   wd_q, wd_d, rd_q, rd_d;
   logic [1:0]    br_q, br_d, rr_q, rr_d;
   logic [7:0]    alu_res;
   logic          alu_cy, alu_ac;
   logic          cy_q, cy_d, ac_q, ac_d;

   pmhps_alu u_alu (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .start    (alu_go_q),
      .op       (pmhps_pkg::pmhps_alu_op_type'(alu_op_q)),
      .acc      (alu_a_q),
      .operand  (alu_b_q),
      .cy_in    (cy_q),
      .ac_in    (ac_q),
      .result_q (alu_res),
      .cy_q     (alu_cy),
      .ac_q     (alu_ac)
   );

   // ==========================================================
   // host side, bus slave, sequencer
   logic        host_wr, host_rd, wr_go, rd_go, ibf_fw_clr, cycle_end;
   logic [7:0]  status_byte;
   logic [31:0] rdat;
   logic [1:0]  rresp;
   logic        alu_done_q;

   always_comb begin
      // RQ5
      host_wr     = host_in.chip_sel & host_in.wr_strobe;
      host_rd     = host_in.chip_sel & host_in.rd_strobe;
      status_byte = {ustat_q, cmd_q, 1'b0, ibf_q, obf_q};
      in_buf_d = in_buf_q;  ibf_d = ibf_q;  cmd_d = cmd_q;
      out_buf_d = out_buf_q; obf_d = obf_q; ustat_d = ustat_q;
      ctrl_d = ctrl_q; p1_d = p1_q; p2_d = p2_q; exp_d = exp_q;
      hd_d = hd_q;  hoe_d = 1'b0;
      alu_a_d = alu_a_q; alu_b_d = alu_b_q; alu_op_d = alu_op_q;
      alu_go_d = 1'b0; alu_acc_d = alu_acc_q;
      cy_d = cy_q; ac_d = ac_q;
      aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q;
      bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
      ibf_fw_clr = 1'b0;
      // host read
      if (host_rd) begin
         hoe_d = 1'b1;                                     // RQ1
         hd_d  = host_in.cmd_flag ? status_byte : out_buf_q; // RQ4 RQ25
         if (!host_in.cmd_flag) begin
            obf_d = 1'b0;
         end
      end
      // axi write channel capture, either order
      if (s_axi_awvalid && !aw_q) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
      end
      wr_go = aw_q & w_q & ~bv_q;
      if (wr_go) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = pmhps_pkg::RESP_OKAY;
         unique case ({awa_q[7:2], 2'b00})
            pmhps_pkg::OFS_CTRL:      ctrl_d  = wd_q[CW-1:0];
            pmhps_pkg::OFS_OUT_BUF: begin
               out_buf_d = wd_q[7:0];
               obf_d     = 1'b1;
            end
            pmhps_pkg::OFS_USER_STAT: ustat_d = wd_q[7:4];
            pmhps_pkg::OFS_PORT1:     p1_d    = wd_q[7:0];
            pmhps_pkg::OFS_PORT2:     p2_d    = wd_q[7:0];
            pmhps_pkg::OFS_ALU_OP: begin
               alu_b_d   = wd_q[7:0];
               alu_a_d   = wd_q[15:8];
               alu_op_d  = wd_q[19:16];
               alu_acc_d = wd_q[20];
               alu_go_d  = 1'b1;                            // RQ23
            end
            pmhps_pkg::OFS_EXP:       exp_d   = wd_q[7:0];
            default: br_d = pmhps_pkg::RESP_SLVERR;
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // read channel
      rdat  = 32'h0000_0000;
      rresp = pmhps_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
         pmhps_pkg::OFS_CTRL:      rdat[CW-1:0] = ctrl_q;
         pmhps_pkg::OFS_STATUS:    rdat[7:0] = status_byte;
         pmhps_pkg::OFS_IN_BUF:    rdat[7:0] = in_buf_q;
         pmhps_pkg::OFS_OUT_BUF:   rdat[7:0] = out_buf_q;
         pmhps_pkg::OFS_USER_STAT: rdat[7:4] = ustat_q;
         pmhps_pkg::OFS_PORT1:     rdat[7:0] = port_one_lines_in & p1_q;
         pmhps_pkg::OFS_PORT2: begin
            rdat[7:0] = port_two_lines_in & p2_q;
            rdat[9:8] = {event_count_input, test_zero_in};  // RQ11
         end
         pmhps_pkg::OFS_ALU_RES:   rdat[15:0] = {cy_q, ac_q, 6'h00,
                                                 alu_res};
         pmhps_pkg::OFS_PC:        rdat[9:0] = pc_q;
         pmhps_pkg::OFS_EXP:       rdat[7:0] = exp_q;
         default:                  rresp = pmhps_pkg::RESP_SLVERR;
      endcase
      rd_go = s_axi_arvalid & ~rv_q;
      if (rd_go) begin
         rv_d = 1'b1;
         rd_d = rdat;
         rr_d = rresp;
         if ({s_axi_araddr[7:2], 2'b00} == pmhps_pkg::OFS_IN_BUF) begin
            ibf_fw_clr = 1'b1;
         end
      end
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      // clear first so a host write wins
      if (ibf_fw_clr) begin
         ibf_d = 1'b0;                                      // RQ26
      end
      if (host_wr) begin
         in_buf_d = host_in.data;                           // RQ3
         cmd_d    = host_in.cmd_flag;                       // RQ2
         ibf_d    = 1'b1;                                   // RQ26
      end
      // alu flags, one cycle late
      if (alu_done_q) begin
         cy_d = alu_cy;                                     // RQ20
         ac_d = alu_ac;                                     // RQ21
      end
   end

   // ==========================================================
   // instruction cycle, timer, vectors
   always_comb begin
      phase_d    = phase_q;
      strobe_d   = 1'b0;
      step_arm_d = step_arm_q;
      pc_d       = pc_q;
      timer_d    = timer_q;
      t1_prev_d  = event_count_input;
      tmr_pend_d = tmr_pend_q;
      ibf_pend_d = ibf_pend_q;
      exp_cnt_d  = exp_cnt_q;
      exp_stb_d  = 1'b0;
      cycle_end  = (phase_q == 2'(pmhps_pkg::CYCLE_CLKS - 1));
      // RQ24: pend on host load
      if (host_wr && ctrl_q[pmhps_pkg::CTL_IBF_IE]) begin
         ibf_pend_d = 1'b1;
      end
      // RQ11: count t1 edges or cycles
      if (ctrl_q[pmhps_pkg::CTL_CNT_SEL] ?
          (event_count_input & ~t1_prev_q) : cycle_end) begin
         timer_d = timer_q + 8'h01;
         if (timer_q == 8'hFF && ctrl_q[pmhps_pkg::CTL_TMR_IE]) begin
            tmr_pend_d = 1'b1;
         end
      end
      // single step stall
      if (!(single_step_in && step_arm_q)) begin             // RQ13
         phase_d = cycle_end ? 2'b00 : phase_q + 2'b01;
      end
      if (!single_step_in) begin
         step_arm_d = 1'b0;
      end
      if (cycle_end && !(single_step_in && step_arm_q)) begin
         strobe_d = 1'b1;                                    // RQ12
         step_arm_d = single_step_in;
         if (ctrl_q[pmhps_pkg::CTL_RUN]) begin
            if (ibf_pend_q) begin
               pc_d       = pmhps_pkg::VEC_IBF;              // RQ16
               ibf_pend_d = 1'b0;
            end else if (tmr_pend_q) begin
               pc_d       = pmhps_pkg::VEC_TIMER;            // RQ17
               tmr_pend_d = 1'b0;
            end else begin
               pc_d = pc_q + 10'h001;                        // RQ18 RQ19
            end
         end
      end
      // expander nibbles and strobe
      if (wr_go && {awa_q[7:2], 2'b00} == pmhps_pkg::OFS_EXP) begin
         exp_cnt_d = 3'h4;
      end else if (exp_cnt_q != 3'h0) begin
         exp_cnt_d = exp_cnt_q - 3'h1;
         exp_stb_d = exp_cnt_q[1];                           // RQ9
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_buf_q <= 8'h00;  out_buf_q <= 8'h00;
         ibf_q <= 1'b0;  obf_q <= 1'b0;  cmd_q <= 1'b0;     // RQ14
         ustat_q <= 4'h0;  ctrl_q <= '0;
         p1_q <= 8'hFF;  p2_q <= 8'hFF;  exp_q <= 8'h00;
         timer_q <= 8'h00;  t1_prev_q <= 1'b0;
         tmr_pend_q <= 1'b0;  ibf_pend_q <= 1'b0;
         pc_q <= pmhps_pkg::VEC_RESET;                       // RQ14 RQ15
         phase_q <= 2'b00;  strobe_q <= 1'b0;  step_arm_q <= 1'b0;
         exp_cnt_q <= 3'h0;  exp_stb_q <= 1'b0;
         hd_q <= 8'h00;  hoe_q <= 1'b0;
         alu_a_q <= 8'h00;  alu_b_q <= 8'h00;  alu_op_q <= 4'h0;
         alu_go_q <= 1'b0;  alu_acc_q <= 1'b0;  alu_done_q <= 1'b0;
         cy_q <= 1'b0;  ac_q <= 1'b0;
         aw_q <= 1'b0;  w_q <= 1'b0;  bv_q <= 1'b0;  rv_q <= 1'b0;
         awa_q <= 8'h00;  wd_q <= 32'h0000_0000;
         rd_q <= 32'h0000_0000;  br_q <= 2'h0;  rr_q <= 2'h0;
      end else begin
         in_buf_q <= in_buf_d;  out_buf_q <= out_buf_d;
         ibf_q <= ibf_d;  obf_q <= obf_d;  cmd_q <= cmd_d;
         ustat_q <= ustat_d;  ctrl_q <= ctrl_d;
         p1_q <= p1_d;  p2_q <= p2_d;  exp_q <= exp_d;
         timer_q <= timer_d;  t1_prev_q <= t1_prev_d;
         tmr_pend_q <= tmr_pend_d;  ibf_pend_q <= ibf_pend_d;
         pc_q <= pc_d;  phase_q <= phase_d;
         strobe_q <= strobe_d;  step_arm_q <= step_arm_d;
         exp_cnt_q <= exp_cnt_d;  exp_stb_q <= exp_stb_d;
         hd_q <= hd_d;  hoe_q <= hoe_d;
         alu_a_q <= alu_a_d;  alu_b_q <= alu_b_d;  alu_op_q <= alu_op_d;
         alu_go_q <= alu_go_d;  alu_acc_q <= alu_acc_d;
         alu_done_q <= alu_go_q;
         cy_q <= cy_d;  ac_q <= ac_d;
         aw_q <= aw_d;  w_q <= w_d;  bv_q <= bv_d;  rv_q <= rv_d;
         awa_q <= awa_d;  wd_q <= wd_d;
         rd_q <= rd_d;  br_q <= br_d;  rr_q <= rr_d;
      end
   end

   // ==========================================================
   // registered outputs
   logic [7:0] p2_mux;
   always_comb begin
      p2_mux = p2_q;                                         // RQ10
      if (exp_cnt_q != 3'h0) begin
         p2_mux[3:0] = exp_cnt_q[2] ? exp_q[7:4] : exp_q[3:0]; // RQ8
      end
      if (ctrl_q[pmhps_pkg::CTL_FLAGS_EN]) begin
         p2_mux[4] = obf_q;                                  // RQ6
         p2_mux[5] = ibf_q;                                  // RQ6
      end
      if (ctrl_q[pmhps_pkg::CTL_DMA_EN]) begin
         p2_mux[6] = ibf_q;                                  // RQ7
         p2_mux[7] = 1'b1;   // ack is an input
      end
   end

   logic [7:0] p2_out_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p2_out_q <= 8'hFF;
      end else begin
         p2_out_q <= p2_mux;
      end
   end

   assign port_one_lines_out  = p1_q;
   assign port_two_lines_out  = p2_out_q;
   assign expander_strobe     = exp_stb_q;
   assign cycle_strobe_out    = strobe_q;
   assign fetch_addr          = pc_q;
   assign program_status_word = {cy_q, ac_q, 6'h00};
   assign host_data_out       = hd_q;
   assign host_data_oe        = hoe_q;
   assign s_axi_awready       = ~aw_q;
   assign s_axi_wready        = ~w_q;
   assign s_axi_bvalid        = bv_q;
   assign s_axi_bresp         = br_q;
   assign s_axi_arready       = ~rv_q;
   assign s_axi_rvalid        = rv_q;
   assign s_axi_rdata         = rd_q;
   assign s_axi_rresp         = rr_q;
endmodule : pmhps_top
`default_nettype wire

// *** verification/pmhps_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmhps_sva (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire pmhps_pkg::pmhps_host_in_type host_in,
   input wire logic                         host_data_oe,
   input wire logic [9:0]                   fetch_addr,
   input wire logic [7:0]                   program_status_word,
   input wire logic                         cycle_strobe_out,
   input wire logic                         single_step_in,
   input wire logic                         expander_strobe,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic                         s_axi_rvalid
);
   // ==========================================================
   // host bus and strobes
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // held step swallows strobes
   sequence s_step_held;
      cycle_strobe_out && single_step_in ##1 single_step_in[*4];
   endsequence
   a_oe_only_read: assert property (host_data_oe |->
      $past(host_in.chip_sel && host_in.rd_strobe)) else $error("oe early");
   a_rd_drives: assert property (host_in.chip_sel && host_in.rd_strobe
      |=> host_data_oe) else $error("read not driven");
   a_unsel_quiet: assert property (!host_in.chip_sel |=>
      !host_data_oe) else $error("bus driven unselected");
   a_reset_zero: assert property ($rose(aresetn) |-> fetch_addr ==
      10'h000 && program_status_word == 8'h00) else $error("reset state");
   a_sync_gap: assert property (cycle_strobe_out |=>
      !cycle_strobe_out[*3]) else $error("extra cycle strobe");
   a_step_hold: assert property (s_step_held |-> !cycle_strobe_out)
      else $error("step did not stall");
   a_exp_pulse: assert property ($rose(expander_strobe) |=>
      expander_strobe ##1 !expander_strobe) else $error("strobe width");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
endmodule : pmhps_sva
bind pmhps_top pmhps_sva u_sva (.*);
`default_nettype wire

// *** verification/pmhps_host_bfm.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmhps_host_bfm (
   input wire logic                          aclk,
   output var pmhps_pkg::pmhps_host_in_type  host_in
);
   initial host_in = '0;
   // ==========================================================
   // released lines show inverted data
   task automatic host_wr(input logic s, input logic c, input logic [7:0] d);
      @(posedge aclk);
      host_in <= '{s, 1'b0, 1'b1, c, d};
      @(posedge aclk);
      host_in <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
   endtask : host_wr
   // strobe held two edges
   task automatic host_rd(input logic c);
      @(posedge aclk);
      host_in <= '{1'b1, 1'b1, 1'b0, c, ~host_in.data};
      repeat (2) @(posedge aclk);
      host_in <= '{1'b0, 1'b0, 1'b0, 1'b0, ~host_in.data};
   endtask : host_rd
endmodule : pmhps_host_bfm
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ==========================================================
   // wiring
   logic aclk = 1'b0, aresetn = 1'b0, test_zero_in = 1'b0;
   logic event_count_input = 1'b0, external_access_in = 1'b0, oe_seen = 1'b0;
   logic [7:0]  port_two_lines_in = 8'hFF, port_one_lines_in = 8'h00;
   logic [3:0]  s_axi_wstrb = 4'hF;
   pmhps_pkg::pmhps_host_in_type host_in;
   logic [7:0]  host_data_out, port_one_lines_out, port_two_lines_out, b;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, program_status_word;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [9:0]  fetch_addr;
   logic        host_data_oe, expander_strobe, cycle_strobe_out, single_step_in;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [33:0] e, aq[$], hq[$];
   integer      seed = 32'hF9BA2F75;
   int          err_count = 0, total_checks = 0;
   pmhps_top u_dut (.*);
   pmhps_host_bfm u_host (.aclk(aclk), .host_in(host_in));
   always #12.5 aclk = ~aclk;
   // ==========================================================
   // checking
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // oldest note vs answer; errors carry no data
   always @(posedge aclk) begin
      oe_seen <= host_data_oe;
      if (s_axi_rvalid && s_axi_rready) begin
         e = aq.pop_front();
         check({s_axi_rresp, e[33] ? 32'h0 : s_axi_rdata}, e);
      end
      if (host_data_oe && !oe_seen)
         check({26'h0, host_data_out}, hq.pop_front());
   end
   // ==========================================================
   // drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      aq.push_back(x);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic hrd(input logic c, input logic [7:0] x);
      hq.push_back({26'h0, x});
      u_host.host_rd(c);
   endtask : hrd
   // bounded wait for a vector
   task automatic wait_pc(input logic [9:0] v, input int n);
      for (int i = 0; i < n && fetch_addr !== v; i++) @(posedge aclk);
      check({24'h0, fetch_addr}, {24'h0, v});
   endtask : wait_pc
   // ==========================================================
   // scenarios
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, single_step_in} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = 32'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h24, 34'h0);
      b = $random(seed);
      port_one_lines_in <= $random(seed);
      u_host.host_wr(1'b0, 1'b0, ~b);
      hrd(1'b1, 8'h00);
      u_host.host_wr(1'b1, 1'b0, b);
      hrd(1'b1, 8'h02);
      rd(8'h08, {26'h0, b});
      hrd(1'b1, 8'h00);
      u_host.host_wr(1'b1, 1'b1, b);
      hrd(1'b1, 8'h0A);
      wr(8'h0C, {24'h0, ~b});
      hrd(1'b1, 8'h0B);
      hrd(1'b0, ~b);
      hrd(1'b1, 8'h0A);
      rd(8'h3C, {2'h2, 32'h0});
      wr(8'h28, $random(seed));
      wr(8'h00, 32'h20);
      single_step_in <= 1'b1;
      repeat (16) @(posedge aclk);
      single_step_in <= 1'b0;
      wait_pc(10'h008, 64);
      wr(8'h00, 32'h21);
      u_host.host_wr(1'b1, 1'b0, b);
      wait_pc(10'h003, 64);
      wait_pc(10'h008, 64);
      wr(8'h00, 32'h22);
      wait_pc(10'h007, 1200);
      report_and_stop();
   end
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
